/* File: tdm_slave_pkg.sv */
// Constants, field layout and register map of the time-multiplexed command and audio slave.
package tdm_slave_pkg;

   // Field geometry: every field is 32 bits, MSB first, low byte meaningless.
   localparam int FIELD_BITS = 32;
   localparam logic [4:0] POS_LAST = 5'h1F;
   localparam logic [4:0] POS_FIRST = 5'h01;
   // Bit counts within a field at which the reply driver turns on, first drives data and lets go.
   localparam logic [4:0] POS_OE_ON = 5'h0F;
   localparam logic [4:0] POS_DRIVE = 5'h10;
   localparam logic [4:0] POS_RELEASE = 5'h18;

   // Command and extended command field layout.
   localparam int CMD_ACQ_BIT = 31;
   localparam int CMD_EXT_BIT = 30;
   localparam int CMD_CHAIN_BIT = 29;
   localparam int CMD_ID_MSB = 28;
   localparam int CMD_ID_LSB = 24;
   localparam int CMD_RW_BIT = 23;
   localparam int CMD_REG_MSB = 22;
   localparam int CMD_REG_LSB = 16;
   localparam int CMD_DATA_LSB = 8;
   localparam int EARLY_PAD = 17;
   // Audio field layout: 24-bit sample left aligned.
   localparam int AUDIO_MSB = 31;
   localparam int AUDIO_LSB = 8;

   localparam logic [4:0] ID_NONE = 5'h00;
   localparam logic [4:0] ID_ALL = 5'h1F;

   // Register indices; the APB byte address is four times the index.
   localparam logic [6:0] REG_IDX_OUT_CTRL = 7'h13;
   localparam logic [6:0] REG_IDX_CHAIN_ID = 7'h17;
   localparam logic [6:0] REG_IDX_STATUS = 7'h18;
   localparam logic [6:0] REG_IDX_AUDIO_L = 7'h19;
   localparam logic [6:0] REG_IDX_AUDIO_R = 7'h1A;
   localparam int OPE_BIT = 4;
   localparam int STAT_MODE_BIT = 0;
   localparam int STAT_ID_FOUND_BIT = 1;
   localparam int APB_IDX_LSB = 2;
   localparam int APB_IDX_TOP = 9;

   // Frame sync detection, and the number of audio channels per device.
   localparam logic [1:0] FS_TDM_WIDTH = 2'h2;
   localparam logic [1:0] FS_LEN_MAX = 2'h3;
   localparam logic [1:0] GOOD_FRAMES = 2'h2;
   localparam logic [1:0] CHANNELS = 2'h2;

   typedef enum logic [1:0] {
      PH_IDLE = 2'b00,
      PH_CMD = 2'b01,
      PH_EXT = 2'b10,
      PH_AUDIO = 2'b11
   } phase_t;

endpackage : tdm_slave_pkg

/* File: tdm_command_audio_slave.sv */
// Receive side of the time-multiplexed command and audio port, with an APB register slave.
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/100ps

module tdm_command_audio_slave
   import tdm_slave_pkg::*;
#(
   parameter int unsigned MAX_ID = 30,
   parameter int unsigned APB_ADDR_W = 12
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [APB_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic bit_clock,
   input wire logic frame_sync,
   input wire logic serial_cmd_in,
   input wire logic chain_token_in,
   output logic reply_out,
   output logic reply_oe_n,
   output logic chain_token_out,
   output logic [23:0] audio_left,
   output logic [23:0] audio_right,
   output logic audio_valid,
   output logic mode_active
);

   generate
      if (MAX_ID < 1 || MAX_ID > 30 || APB_ADDR_W < APB_IDX_TOP)
      begin : g_bad_param
         $error("tdm_command_audio_slave: unsupported parameter value");
      end
   endgenerate

   typedef struct packed {
      logic bck_s1;
      logic bck_s2;
      logic bck_s3;
      logic fs_s1;
      logic fs_s2;
      logic din_s1;
      logic din_s2;
      logic tok_s1;
      logic tok_s2;
      logic fs_prev;
      logic [1:0] hi_len;
      logic [1:0] good_cnt;
      logic cmd_ok;
      phase_t phase;
      logic [4:0] fpos;
      logic [31:0] sr;
      logic had_ext;
      logic acq;
      logic acq_found;
      logic [4:0] acq_cnt;
      logic [4:0] my_id;
      logic output_channel_disable;
      logic own;
      logic done;
      logic [1:0] taken;
      logic [23:0] aud_l;
      logic [23:0] aud_r;
      logic aud_valid;
      logic read_pend;
      logic [7:0] rsh;
      logic reply_out;
      logic reply_oe_n;
      logic tok_out;
      logic [31:0] prdata;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   logic bck_rise;
   logic bck_fall;
   logic field_end;
   logic frame_start;
   logic [31:0] word;
   logic [31:0] early_word;
   logic read_cond;
   logic [7:0] rd_val;
   logic [6:0] apb_idx;
   logic apb_mapped;
   logic [31:0] apb_rd;

   // Addressing: input chain only, own identifier, or broadcast for writes.
   function automatic logic addr_hit(input logic [31:0] w, input logic [4:0] id);
      logic [4:0] tid;
      tid = w[CMD_ID_MSB:CMD_ID_LSB];
      addr_hit = !w[CMD_CHAIN_BIT] && ((tid == id && id != ID_NONE) || (tid == ID_ALL && !w[CMD_RW_BIT]));
   endfunction : addr_hit

   function automatic logic [7:0] reg_value(input logic [6:0] idx, input logic output_channel_disable, input logic [4:0] id);
      reg_value = 8'h00;
      case (idx)
         REG_IDX_OUT_CTRL: reg_value[OPE_BIT] = output_channel_disable;
         REG_IDX_CHAIN_ID: reg_value[4:0] = id;
         default: reg_value = 8'h00;
      endcase
   endfunction : reg_value

   // The edge detectors read only the second and third stages, never the first.
   assign bck_rise = s_r.bck_s2 && !s_r.bck_s3;
   assign bck_fall = !s_r.bck_s2 && s_r.bck_s3;
   assign frame_start = bck_rise && s_r.fs_s2 && !s_r.fs_prev;
   assign field_end = bck_rise && !frame_start && s_r.fpos == POS_LAST;
   assign word = {s_r.sr[30:0], s_r.din_s2};
   // Only bits 31..17 have arrived when the driver must turn on; the index is not needed yet.
   assign early_word = {s_r.sr[14:0], {EARLY_PAD{1'b0}}};
   assign read_cond = s_r.cmd_ok && (s_r.phase == PH_CMD || s_r.phase == PH_EXT) && addr_hit(early_word, s_r.my_id)
      && early_word[CMD_RW_BIT] && !(s_r.phase == PH_CMD && early_word[CMD_ACQ_BIT]);
   assign rd_val = reg_value(s_r.sr[6:0], s_r.output_channel_disable, s_r.my_id);

   assign apb_idx = paddr[APB_IDX_TOP-1:APB_IDX_LSB];
   assign apb_mapped = paddr[APB_IDX_LSB-1:0] == '0 && (paddr >> APB_IDX_TOP) == '0
      && (apb_idx == REG_IDX_OUT_CTRL || apb_idx == REG_IDX_CHAIN_ID || apb_idx == REG_IDX_STATUS
      || apb_idx == REG_IDX_AUDIO_L || apb_idx == REG_IDX_AUDIO_R);

   always_comb
   begin
      apb_rd = 32'h0000_0000;
      case (apb_idx)
         REG_IDX_OUT_CTRL: apb_rd[7:0] = reg_value(apb_idx, s_r.output_channel_disable, s_r.my_id);
         REG_IDX_CHAIN_ID: apb_rd[7:0] = reg_value(apb_idx, s_r.output_channel_disable, s_r.my_id);
         REG_IDX_STATUS:
         begin
            apb_rd[STAT_MODE_BIT] = s_r.good_cnt == GOOD_FRAMES;
            apb_rd[STAT_ID_FOUND_BIT] = s_r.acq_found;
         end
         REG_IDX_AUDIO_L: apb_rd[23:0] = s_r.aud_l;
         REG_IDX_AUDIO_R: apb_rd[23:0] = s_r.aud_r;
         default: apb_rd = 32'h0000_0000;
      endcase
      if (!apb_mapped)
      begin
         apb_rd = 32'h0000_0000;
      end
   end

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.aud_valid = 1'b0;
      s_nxt.bck_s1 = bit_clock;
      s_nxt.bck_s2 = s_r.bck_s1;
      s_nxt.bck_s3 = s_r.bck_s2;
      s_nxt.fs_s1 = frame_sync;
      s_nxt.fs_s2 = s_r.fs_s1;
      s_nxt.din_s1 = serial_cmd_in;
      s_nxt.din_s2 = s_r.din_s1;
      s_nxt.tok_s1 = chain_token_in;
      s_nxt.tok_s2 = s_r.tok_s1;

      if (bck_rise)
      begin
         s_nxt.fs_prev = s_r.fs_s2;
         s_nxt.sr = word;
         s_nxt.fpos = 5'(s_r.fpos + 5'h01);
         if (s_r.fs_s2 && s_r.hi_len != FS_LEN_MAX)
            s_nxt.hi_len = 2'(s_r.hi_len + 2'h1);
         // A 50% word clock stays high far longer than two bits and clears the mode.
         if (!s_r.fs_s2 && s_r.fs_prev)
         begin
            if (s_r.hi_len == FS_TDM_WIDTH)
            begin
               if (s_r.good_cnt != GOOD_FRAMES)
                  s_nxt.good_cnt = 2'(s_r.good_cnt + 2'h1);
            end
            else
            begin
               s_nxt.good_cnt = 2'h0;
               s_nxt.cmd_ok = 1'b0;
            end
         end
         if (s_r.acq && !s_r.acq_found)
         begin
            if (s_r.tok_s2)
            begin
               s_nxt.acq_found = 1'b1;
               s_nxt.my_id = (6'(s_r.acq_cnt) + 6'h01 > 6'(MAX_ID)) ? ID_NONE : 5'(s_r.acq_cnt + 5'h01);
            end
            else if (s_r.acq_cnt != ID_ALL)
               s_nxt.acq_cnt = 5'(s_r.acq_cnt + 5'h01);
         end
      end

      if (frame_start)
      begin
         s_nxt.hi_len = 2'h1;
         s_nxt.cmd_ok = s_r.good_cnt == GOOD_FRAMES;
         s_nxt.phase = PH_CMD;
         s_nxt.fpos = POS_FIRST;
         s_nxt.had_ext = 1'b0;
         s_nxt.acq = 1'b0;
         s_nxt.own = 1'b0;
         s_nxt.done = s_r.output_channel_disable;
         s_nxt.taken = 2'h0;
         s_nxt.read_pend = 1'b0;
         s_nxt.reply_oe_n = 1'b1;
      end
      else if (field_end)
      begin
         case (s_r.phase)
            PH_CMD, PH_EXT:
            begin
               if (!s_r.cmd_ok)
                  s_nxt.phase = PH_IDLE;
               else if (s_r.phase == PH_CMD && word[CMD_ACQ_BIT])
               begin
                  s_nxt.phase = PH_IDLE;
                  s_nxt.acq = 1'b1;
                  s_nxt.acq_found = 1'b0;
                  s_nxt.acq_cnt = 5'h00;
               end
               else
               begin
                  if (addr_hit(word, s_r.my_id) && !word[CMD_RW_BIT] && word[CMD_REG_MSB:CMD_REG_LSB] == REG_IDX_OUT_CTRL)
                     s_nxt.output_channel_disable = word[CMD_DATA_LSB + OPE_BIT];
                  if (word[CMD_EXT_BIT])
                  begin
                     s_nxt.phase = PH_EXT;
                     s_nxt.had_ext = 1'b1;
                  end
                  else if (s_r.had_ext || s_r.phase == PH_EXT)
                     s_nxt.phase = PH_IDLE;
                  else
                     s_nxt.phase = PH_AUDIO;
               end
            end
            PH_AUDIO:
            begin
               if (s_r.own)
               begin
                  if (s_r.taken == 2'h0)
                     s_nxt.aud_l = word[AUDIO_MSB:AUDIO_LSB];
                  else
                     s_nxt.aud_r = word[AUDIO_MSB:AUDIO_LSB];
                  s_nxt.taken = 2'(s_r.taken + 2'h1);
                  if (2'(s_r.taken + 2'h1) == CHANNELS)
                  begin
                     s_nxt.own = 1'b0;
                     s_nxt.done = 1'b1;
                     s_nxt.aud_valid = 1'b1;
                  end
               end
            end
            PH_IDLE: s_nxt.phase = PH_IDLE;
            default: s_nxt.phase = PH_IDLE;
         endcase
         // A high token at the end of a slot hands the next slot to this device.
         if (s_nxt.phase == PH_AUDIO && !s_nxt.own && !s_nxt.done && s_r.tok_s2)
            s_nxt.own = 1'b1;
      end

      if (bck_fall)
      begin
         if (s_r.fpos == POS_OE_ON && read_cond)
         begin
            s_nxt.read_pend = 1'b1;
            s_nxt.reply_oe_n = 1'b0;
            s_nxt.reply_out = 1'b0;
         end
         else if (s_r.read_pend)
         begin
            if (s_r.fpos == POS_DRIVE)
            begin
               s_nxt.reply_out = rd_val[7];
               s_nxt.rsh = {rd_val[6:0], 1'b0};
            end
            else if (s_r.fpos > POS_DRIVE && s_r.fpos < POS_RELEASE)
            begin
               s_nxt.reply_out = s_r.rsh[7];
               s_nxt.rsh = {s_r.rsh[6:0], 1'b0};
            end
            else if (s_r.fpos == POS_RELEASE)
            begin
               s_nxt.reply_oe_n = 1'b1;
               s_nxt.read_pend = 1'b0;
            end
         end
      end

      if (s_r.acq)
         s_nxt.tok_out = s_r.acq_found;
      else if (s_r.output_channel_disable)
         s_nxt.tok_out = s_r.tok_s2;
      else
         s_nxt.tok_out = s_r.phase == PH_AUDIO && s_r.own && s_r.taken == 2'h1;

      // Read data is captured in the setup cycle so the access phase needs no wait state.
      if (psel && !penable)
         s_nxt.prdata = apb_rd;
      // A software write lands after the serial path so the APB write wins a collision.
      if (psel && penable && pwrite && apb_mapped && apb_idx == REG_IDX_OUT_CTRL)
         s_nxt.output_channel_disable = pwdata[OPE_BIT];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_r <= '0;
         s_r.reply_oe_n <= 1'b1;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign pready = 1'b1;
   assign pslverr = psel && penable && !apb_mapped;
   assign prdata = s_r.prdata;
   assign reply_out = s_r.reply_out;
   assign reply_oe_n = s_r.reply_oe_n;
   assign chain_token_out = s_r.tok_out;
   assign audio_left = s_r.aud_l;
   assign audio_right = s_r.aud_r;
   assign audio_valid = s_r.aud_valid;
   assign mode_active = s_r.good_cnt == GOOD_FRAMES;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   chk_oe_turn_on: assert property ($fell(reply_oe_n) |-> $past(bck_fall) && $past(s_r.fpos) == POS_OE_ON)
      else $error("reply driver turned on at the wrong bit");
   chk_low_byte_quiet: assert property (!reply_oe_n |-> s_r.fpos >= POS_OE_ON && s_r.fpos <= POS_RELEASE)
      else $error("reply driven outside the data window");
   chk_out_on_fall: assert property ($changed(reply_out) |-> $past(bck_fall))
      else $error("reply output changed away from a falling bit clock");
   chk_read_first_bit: assert property (bck_fall && s_r.fpos == POS_DRIVE && s_r.read_pend
      |=> reply_out == $past(rd_val[7]) && !reply_oe_n)
      else $error("first read bit does not match register");
   chk_oe_only_read: assert property (!reply_oe_n |-> s_r.read_pend && s_r.cmd_ok)
      else $error("reply driven without an addressed read");
   chk_ext_no_audio: assert property (s_r.had_ext |-> s_r.phase != PH_AUDIO && !audio_valid)
      else $error("audio taken in a frame with extended fields");
   chk_mode_entry: assert property ($rose(s_r.cmd_ok) |-> $past(frame_start) && $past(s_r.good_cnt) == GOOD_FRAMES)
      else $error("commands accepted before mode entry");
   chk_id_range: assert property (s_r.my_id != ID_ALL && 6'(s_r.my_id) <= 6'(MAX_ID))
      else $error("chain identifier out of range");
   chk_acq_id: assert property ($rose(s_r.acq_found) |-> s_r.my_id == ID_NONE
      || s_r.my_id == 5'($past(s_r.acq_cnt) + 5'h01))
      else $error("acquired identifier does not match bit count");
   chk_token_pass: assert property (s_r.output_channel_disable && !s_r.acq |=> chain_token_out == $past(s_r.tok_s2))
      else $error("token not passed through with channels disabled");
   chk_token_last: assert property (s_r.phase == PH_AUDIO && s_r.own && s_r.taken == 2'h1 && !s_r.acq && !s_r.output_channel_disable
      |=> chain_token_out)
      else $error("token not raised in last channel slot");

   cov_read_reply: cover property ($fell(reply_oe_n) ##[1:300] $rose(reply_oe_n));
   cov_id_found: cover property ($rose(s_r.acq_found));
   cov_audio_pair: cover property (audio_valid);
   cov_mode_entry: cover property ($rose(mode_active));

endmodule : tdm_command_audio_slave

/* File: tdm_host_model.sv */
// Host model: makes the bit clock and frame sync, shifts fields out and captures the reply.
`timescale 1ns/100ps
module tdm_host_model
(
   input wire logic pclk,
   input wire logic reply_wire,
   input wire logic reply_oe_n,
   input wire logic chain_token_out,
   output logic bit_clock,
   output logic frame_sync,
   output logic serial_cmd_in
);
   logic [31:0] fields[$];
   logic [31:0] rep_cap[$];
   logic [31:0] oe_cap[$];
   logic [31:0] tok_cap[$];

   initial
   begin
      bit_clock = 1'b0;
      frame_sync = 1'b0;
      serial_cmd_in = 1'b0;
   end

   task automatic half_bit();
      repeat (4) @(posedge pclk);
   endtask : half_bit

   // The bit clock stands low between frames, and the data line then shows the inverse of its last bit.
   task automatic run_frame();
      logic [31:0] r;
      logic [31:0] o;
      logic [31:0] t;
      int n;
      n = 0;
      rep_cap.delete();
      oe_cap.delete();
      tok_cap.delete();
      foreach (fields[f])
      begin
         for (int b = 31; b >= 0; b--)
         begin
            bit_clock <= 1'b0;
            serial_cmd_in <= fields[f][b];
            frame_sync <= (n < 2);
            n++;
            half_bit();
            bit_clock <= 1'b1;
            r[b] = reply_wire;
            o[b] = ~reply_oe_n;
            t[b] = chain_token_out;
            half_bit();
         end
         rep_cap.push_back(r);
         oe_cap.push_back(o);
         tok_cap.push_back(t);
      end
      bit_clock <= 1'b0;
      frame_sync <= 1'b0;
      serial_cmd_in <= ~serial_cmd_in;
   endtask : run_frame
endmodule : tdm_host_model

/* File: tdm_command_audio_slave_tb.sv */
// Self-checking bench for the time-multiplexed command and audio slave.
`timescale 1ns/100ps
module tdm_command_audio_slave_tb;
   import tdm_slave_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, hit;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, exp_rd;
   logic bit_clock, frame_sync, serial_cmd_in, chain_token_in;
   logic reply_out, reply_oe_n, reply_wire, chain_token_out, audio_valid, mode_active;
   logic [23:0] audio_left, audio_right, samp_l, samp_r, exp_l, exp_r;
   logic [31:0] rcmd[6] = '{32'h01970000, 32'h01930000, 32'h02970000, 32'h21970000, 32'h1F970000, 32'h00970000};
   int failures, comparisons, exp_valid, exp_ctrl, exp_id;
   int valid_count = 0;
   integer seed = 18460;

   // The reply wire has a pull-up, so a released driver reads high.
   assign reply_wire = reply_oe_n ? 1'b1 : reply_out;

   tdm_command_audio_slave #(.MAX_ID(30), .APB_ADDR_W(12)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bit_clock(bit_clock), .frame_sync(frame_sync), .serial_cmd_in(serial_cmd_in),
      .chain_token_in(chain_token_in), .reply_out(reply_out), .reply_oe_n(reply_oe_n),
      .chain_token_out(chain_token_out), .audio_left(audio_left), .audio_right(audio_right),
      .audio_valid(audio_valid), .mode_active(mode_active));

   tdm_host_model host (.pclk(pclk), .reply_wire(reply_wire), .reply_oe_n(reply_oe_n),
      .chain_token_out(chain_token_out), .bit_clock(bit_clock), .frame_sync(frame_sync),
      .serial_cmd_in(serial_cmd_in));

   initial
   begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   always @(posedge pclk)
   begin
      if (audio_valid === 1'b1)
         valid_count <= valid_count + 1;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // No timeout here: only pready or the watchdog ends a wait for pready.
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic rdc(input logic [11:0] addr, input logic [31:0] exp, input logic exp_err);
      apb(1'b0, addr, 32'h0);
      check(rd, exp);
      check({31'h0, err}, {31'h0, exp_err});
   endtask : rdc

   // Audio fields are also sent after an extended field on purpose, to see that they are dropped.
   task automatic send(input logic [31:0] cmd, input logic [31:0] ext, input logic audio);
      host.fields.delete();
      host.fields.push_back(cmd);
      if (cmd[CMD_EXT_BIT] && !cmd[CMD_ACQ_BIT])
         host.fields.push_back(ext);
      samp_l = 24'($random(seed));
      samp_r = 24'($random(seed));
      if (audio)
      begin
         host.fields.push_back({samp_l, 8'h00});
         host.fields.push_back({samp_r, 8'h00});
         host.fields.push_back(32'h00000000);
      end
      host.run_frame();
      repeat (12) @(posedge pclk);
   endtask : send

   task automatic audio_chk();
      check({8'h00, audio_left}, {8'h00, exp_l});
      check({8'h00, audio_right}, {8'h00, exp_r});
      check(valid_count, exp_valid);
      rdc(12'h064, {8'h00, exp_l}, 1'b0);
      rdc(12'h068, {8'h00, exp_r}, 1'b0);
   endtask : audio_chk

   task automatic stop_test();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : stop_test

   initial
   begin
      #2000000;
      failures++;
      $display("mismatch at %0t: run did not finish", $time);
      stop_test();
   end

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      chain_token_in = 1'b1;
      failures = 0;
      comparisons = 0;
      exp_valid = 0;
      exp_ctrl = 0;
      exp_id = 0;
      exp_l = 24'h0;
      exp_r = 24'h0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdc(12'h04C, 32'h0, 1'b0);
      rdc(12'h05C, 32'h0, 1'b0);
      rdc(12'h060, 32'h0, 1'b0);
      rdc(12'h050, 32'h0, 1'b1);
      rdc(12'h04D, 32'h0, 1'b1);
      apb(1'b1, 12'h05C, 32'h0000001F);
      rdc(12'h05C, 32'h0, 1'b0);
      apb(1'b1, 12'h04C, 32'hFFFFFFFF);
      rdc(12'h04C, 32'h00000010, 1'b0);
      apb(1'b1, 12'h04C, 32'h0);
      rdc(12'h04C, 32'h0, 1'b0);
      // Commands inside the two entry frames are not honoured.
      send(32'h1F131000, 32'h0, 1'b0);
      send(32'h1F131000, 32'h0, 1'b0);
      check({31'h0, mode_active}, 32'h1);
      rdc(12'h04C, 32'h0, 1'b0);
      // Acquisition as chain head; the other bits of that field address the output chain, so they would not set channel disable.
      send(32'hFF131000, 32'h0, 1'b1);
      exp_id = 1;
      rdc(12'h05C, exp_id, 1'b0);
      rdc(12'h060, 32'h3, 1'b0);
      rdc(12'h04C, 32'h0, 1'b0);
      audio_chk();
      // Broadcast write, then an extended field that selects nobody, then audio that must be dropped.
      send(32'h5F131000, 32'h00130000, 1'b1);
      exp_ctrl = 32'h10;
      rdc(12'h04C, exp_ctrl, 1'b0);
      audio_chk();
      chain_token_in <= 1'b0;
      repeat (8) @(posedge pclk);
      check({31'h0, chain_token_out}, 32'h0);
      chain_token_in <= 1'b1;
      repeat (8) @(posedge pclk);
      check({31'h0, chain_token_out}, 32'h1);
      // With both channels disabled the audio slots are skipped and the token passes straight through.
      send(32'h00000000, 32'h0, 1'b1);
      audio_chk();
      check({31'h0, host.tok_cap[1][15]}, 32'h1);
      apb(1'b1, 12'h04C, 32'h0);
      exp_ctrl = 0;
      // Only a read addressed to this input-chain device may drive the reply wire.
      for (int i = 0; i < 6; i++)
      begin
         hit = (rcmd[i][CMD_ID_MSB:CMD_ID_LSB] == 5'h01) && !rcmd[i][CMD_CHAIN_BIT];
         exp_rd = (rcmd[i][CMD_REG_MSB:CMD_REG_LSB] == REG_IDX_CHAIN_ID) ? exp_id : exp_ctrl;
         send(rcmd[i], 32'h0, 1'b1);
         exp_l = samp_l;
         exp_r = samp_r;
         exp_valid++;
         check(host.oe_cap[0], hit ? 32'h0001FF00 : 32'h0);
         if (hit)
            check({24'h0, host.rep_cap[0][15:8]}, exp_rd & 32'hFF);
         check({31'h0, host.tok_cap[1][15]}, 32'h0);
         check({31'h0, host.tok_cap[2][15]}, 32'h1);
         audio_chk();
      end
      stop_test();
   end
endmodule : tdm_command_audio_slave_tb
